/* File: logic/nibble_data_pkg.sv */
// Register map, field layout and reset values of the nibble data words
package nibble_data_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] addr_control = 12'h000;
    localparam logic [11:0] addr_data_low = 12'h004;
    localparam logic [11:0] addr_data_high = 12'h008;
    localparam int addr_msb = 11;
    localparam int word_width = 16;
    // ------------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------------
    localparam int ctl_receive_bit = 0;
    localparam int ctl_check_bit = 1;
    // ------------------------------------------------------------------
    // Nibble field positions (low bit of each field)
    // ------------------------------------------------------------------
    localparam int nib_hi_lsb = 12;
    localparam int nib_mh_lsb = 8;
    localparam int nib_ml_lsb = 4;
    localparam int nib_lo_lsb = 0;
    localparam int nib_width = 4;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] data_reset = 16'h0000;
    localparam logic [1:0] control_reset = 2'h0;
    localparam logic [31:0] read_zero = 32'h0000_0000;
endpackage

/* File: logic/nibble_data_regs.sv */
// APB register block holding one frame's status, data and check nibbles
//
// Functional notes
// - Low word: nibbles four, five, six, check
// - High word: status, nibbles one, two, three
// - Receive mode makes every nibble read-only
// - Transmit with auto check locks check nibble
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module nibble_data_regs
    import nibble_data_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode levels toward the frame engine
    output logic receive_mode_enable,
    output logic auto_check_enable,
    // Receive path loads a captured frame
    input wire logic rx_load,
    input wire logic [15:0] rx_data_low,
    input wire logic [15:0] rx_data_high
);

    typedef struct packed {
        logic [15:0] data_low;
        logic [15:0] data_high;
        logic receive_en;
        logic check_en;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } state_s;

    state_s st;
    state_s next_st;

    logic setup;
    logic wr;
    logic hit;
    logic [15:0] wmask_low;
    logic [15:0] wmask_high;
    logic [15:0] lane_mask;

    // ------------------------------------------------------------------
    // Decode of the setup phase
    // ------------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr = setup && pwrite;
    assign hit = (paddr == addr_control) || (paddr == addr_data_low)
        || (paddr == addr_data_high);
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Write masks follow the mode: receive locks all, auto check locks CRC
    always_comb begin
        wmask_low = 16'hFFFF;
        wmask_high = 16'hFFFF;
        if (st.receive_en) begin
            wmask_low = 16'h0000;
            wmask_high = 16'h0000;
        end else if (st.check_en) begin
            wmask_low[nib_lo_lsb +: nib_width] = 4'h0;
        end
        wmask_low = wmask_low & lane_mask;
        wmask_high = wmask_high & lane_mask;
    end

    // Next state: zero-wait-state APB slave plus field update
    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        if (rx_load && st.receive_en) begin
            next_st.data_low = rx_data_low;
            next_st.data_high = rx_data_high;
        end
        if (setup) begin
            next_st.ready = 1'b1;
            next_st.err = !hit;
            next_st.rdata = read_zero;
            if (!pwrite) begin
                unique case (paddr)
                    addr_control: begin
                        next_st.rdata[ctl_receive_bit] = st.receive_en;
                        next_st.rdata[ctl_check_bit] = st.check_en;
                    end
                    addr_data_low: begin
                        next_st.rdata[word_width-1:0] = st.data_low;
                    end
                    addr_data_high: begin
                        next_st.rdata[word_width-1:0] = st.data_high;
                    end
                    default: begin
                        next_st.rdata = read_zero;
                    end
                endcase
            end
        end
        if (wr) begin
            unique case (paddr)
                addr_control: begin
                    if (pstrb[0]) begin
                        next_st.receive_en = pwdata[ctl_receive_bit];
                        next_st.check_en = pwdata[ctl_check_bit];
                    end
                end
                addr_data_low: begin
                    // Locked bits keep the loaded frame, so capture wins
                    next_st.data_low = (next_st.data_low & ~wmask_low)
                        | (pwdata[word_width-1:0] & wmask_low);
                end
                addr_data_high: begin
                    next_st.data_high = (next_st.data_high & ~wmask_high)
                        | (pwdata[word_width-1:0] & wmask_high);
                end
                default: begin
                    next_st.ready = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.data_low <= data_reset;
            st.data_high <= data_reset;
            st.receive_en <= control_reset[ctl_receive_bit];
            st.check_en <= control_reset[ctl_check_bit];
            st.rdata <= read_zero;
            st.ready <= 1'b0;
            st.err <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------------
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign receive_mode_enable = st.receive_en;
    assign auto_check_enable = st.check_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_rx_locks_low;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_low && st.receive_en && !rx_load)
            |=> $stable(st.data_low);
    endproperty
    a_rx_locks_low: assert property (p_rx_locks_low)
        else $error("low word changed by write in receive mode");

    property p_rx_locks_high;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_high && st.receive_en && !rx_load)
            |=> $stable(st.data_high);
    endproperty
    a_rx_locks_high: assert property (p_rx_locks_high)
        else $error("high word changed by write in receive mode");

    property p_crc_locked;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_low && !st.receive_en && st.check_en)
            |=> st.data_low[nib_lo_lsb +: nib_width]
            == $past(st.data_low[nib_lo_lsb +: nib_width]);
    endproperty
    a_crc_locked: assert property (p_crc_locked)
        else $error("check nibble written while auto check on");

    property p_tx_data_writable;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_low && !st.receive_en && pstrb[1])
            |=> st.data_low[15:8] == $past(pwdata[15:8]);
    endproperty
    a_tx_data_writable: assert property (p_tx_data_writable)
        else $error("data nibbles not written in transmit mode");

    property p_tx_full_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_low && !st.receive_en && !st.check_en
            && pstrb[0]) |=> st.data_low[7:0] == $past(pwdata[7:0]);
    endproperty
    a_tx_full_write: assert property (p_tx_full_write)
        else $error("check nibble not writable without auto check");

    property p_read_low;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == addr_data_low)
            |=> prdata == {16'h0000, $past(st.data_low)} && pready;
    endproperty
    a_read_low: assert property (p_read_low)
        else $error("low word read data wrong");

    property p_read_high;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == addr_data_high)
            |=> prdata[nib_hi_lsb +: nib_width]
            == $past(st.data_high[nib_hi_lsb +: nib_width]) && pready;
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("status nibble read data wrong");

    property p_ready_once;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("pready held longer than one cycle");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup && !hit) |=> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    property p_rx_load_low;
        @(posedge pclk) disable iff (!presetn)
        (rx_load && st.receive_en) |=> st.data_low == $past(rx_data_low);
    endproperty
    a_rx_load_low: assert property (p_rx_load_low)
        else $error("captured low word not loaded");

    property p_rx_load_high;
        @(posedge pclk) disable iff (!presetn)
        (rx_load && st.receive_en) |=> st.data_high == $past(rx_data_high);
    endproperty
    a_rx_load_high: assert property (p_rx_load_high)
        else $error("captured high word not loaded");

    property p_tx_high_upper;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_high && !st.receive_en && pstrb[1])
            |=> st.data_high[nib_hi_lsb +: nib_width]
            == $past(pwdata[nib_hi_lsb +: nib_width]);
    endproperty
    a_tx_high_upper: assert property (p_tx_high_upper)
        else $error("status nibble not written in transmit mode");

    property p_tx_high_lower;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_high && !st.receive_en && pstrb[0])
            |=> st.data_high[nib_lo_lsb +: nib_width]
            == $past(pwdata[nib_lo_lsb +: nib_width]);
    endproperty
    a_tx_high_lower: assert property (p_tx_high_lower)
        else $error("third data nibble not written in transmit mode");

    property p_lane_keep;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_data_low && !pstrb[1] && !st.receive_en)
            |=> $stable(st.data_low[nib_hi_lsb +: nib_width]);
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("byte without strobe was written");

    property p_read_control;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == addr_control)
            |=> prdata[ctl_receive_bit] == $past(st.receive_en)
            && prdata[ctl_check_bit] == $past(st.check_en);
    endproperty
    a_read_control: assert property (p_read_control)
        else $error("control read data wrong");

    property p_ctl_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == addr_control && pstrb[0])
            |=> receive_mode_enable == $past(pwdata[ctl_receive_bit])
            && auto_check_enable == $past(pwdata[ctl_check_bit]);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("mode bits not written");

    property p_idle_no_ready;
        @(posedge pclk) disable iff (!presetn)
        !setup |=> !pready && !pslverr;
    endproperty
    a_idle_no_ready: assert property (p_idle_no_ready)
        else $error("answer without a setup phase");

    property p_mapped_ok;
        @(posedge pclk) disable iff (!presetn)
        (setup && hit) |=> !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("mapped access flagged as error");

    property p_unmapped_quiet;
        @(posedge pclk) disable iff (!presetn)
        (wr && !hit && !(rx_load && st.receive_en))
            |=> $stable(st.data_low) && $stable(st.data_high)
            && $stable(st.receive_en) && $stable(st.check_en);
    endproperty
    a_unmapped_quiet: assert property (p_unmapped_quiet)
        else $error("unmapped write changed state");

    c_rx_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr && st.receive_en);
    c_crc_lock: cover property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == addr_data_low && st.check_en && !st.receive_en);
    c_read_high: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == addr_data_high);
    c_rx_collide: cover property (@(posedge pclk) disable iff (!presetn)
        wr && rx_load && st.receive_en);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !hit);
endmodule

/* File: tb/frame_source_model.sv */
// Far-side model of the link engine handing captured frames to the words
`timescale 1ns/1ps
module frame_source_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command from the bench
    input wire logic go,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi,
    // Frame words toward the register block
    output logic rx_load,
    output logic [15:0] rx_data_low,
    output logic [15:0] rx_data_high
);
    // One-cycle load pulse; outside it the words keep toggling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_load <= 1'b0;
            rx_data_low <= 16'h0000;
            rx_data_high <= 16'h0000;
        end else if (go) begin
            rx_load <= 1'b1;
            rx_data_low <= lo;
            rx_data_high <= hi;
        end else begin
            rx_load <= 1'b0;
            rx_data_low <= ~rx_data_low; // Stale value never looks valid
            rx_data_high <= ~rx_data_high;
        end
    end
endmodule

/* File: tb/sent_nibble_data_regs_tb.sv */
// Self-checking bench of the nibble data register block
`timescale 1ns/1ps
module sent_nibble_data_regs_tb;
    import nibble_data_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, go = 1'b0, e, rx_load, pready, pslverr, rme, ace;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [3:0] pstrb = 4'h0;
    logic [15:0] lo = 16'h0000, hi = 16'h0000, rxl, rxh;
    int failures = 0, samples_checked = 0, cycles = 0;
    nibble_data_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_mode_enable(rme), .auto_check_enable(ace),
        .rx_load(rx_load), .rx_data_low(rxl), .rx_data_high(rxh));
    frame_source_model far (.pclk(pclk), .presetn(presetn), .go(go),
        .lo(lo), .hi(hi), .rx_load(rx_load), .rx_data_low(rxl),
        .rx_data_high(rxh));
    // Clock and hang limit
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, x);
        samples_checked++;
        if (s !== x) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk("read", r, x);
    endtask
    task automatic frame(input logic [15:0] l, h);
        @(posedge pclk);
        lo <= l;
        hi <= h;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(addr_data_low, 32'h0000_0000);
        rd(addr_data_high, 32'h0000_0000);
        apb(1'b1, addr_data_low, 32'h0000_1234, 4'h3);
        rd(addr_data_low, 32'h0000_1234);
        apb(1'b1, addr_data_high, 32'h0000_abcd, 4'h3);
        rd(addr_data_high, 32'h0000_abcd);
        $display("test transmit done");
        apb(1'b1, addr_control, 32'h0000_0002, 4'h3);
        chk("auto check", {31'h0, ace}, 32'h0000_0001);
        rd(addr_control, 32'h0000_0002);
        apb(1'b1, addr_data_low, 32'h0000_5678, 4'h3);
        rd(addr_data_low, 32'h0000_5674);
        apb(1'b1, addr_data_high, 32'h0000_1357, 4'h3);
        rd(addr_data_high, 32'h0000_1357);
        $display("test auto check done");
        apb(1'b1, addr_control, 32'h0000_0001, 4'h3);
        chk("receive mode", {31'h0, rme}, 32'h0000_0001);
        apb(1'b1, addr_data_low, 32'h0000_ffff, 4'h3);
        apb(1'b1, addr_data_high, 32'h0000_ffff, 4'h3);
        rd(addr_data_low, 32'h0000_5674);
        rd(addr_data_high, 32'h0000_1357);
        fork
            frame(16'h9abc, 16'h2468);
            begin
                @(posedge pclk);
                apb(1'b1, addr_data_low, 32'h0000_0f0f, 4'h3);
            end
        join
        rd(addr_data_low, 32'h0000_9abc);
        rd(addr_data_high, 32'h0000_2468);
        $display("test receive done");
        apb(1'b1, addr_control, 32'h0000_0000, 4'h3);
        frame(16'h1111, 16'h2222);
        apb(1'b1, addr_data_low, 32'h0000_0055, 4'h1);
        rd(addr_data_low, 32'h0000_9a55);
        rd(addr_data_high, 32'h0000_2468);
        apb(1'b1, 12'h00c, 32'h0000_0000, 4'h0);
        chk("unmapped", {31'h0, e}, 32'h0000_0001);
        chk("unmapped data", r, 32'h0000_0000);
        $display("test transmit again done");
        results();
    end
endmodule
